// File: lstc_defs.svh
// register map, field positions, reset values and timing counts
//------------------------------------------------------------
// Contract
// - buffer holds 255 words of 48 bits per board; eight comparators
// - probe pins sampled every master clock, keeping pace with 10MHz events
// - trace enabled from arming until capture stops; depth one to eight levels
// - at most 255 stored events; only qualified events are written
// - programmable number of stored events before or after completion
// - sequence completion drives a synchronizing pulse out
// - each of eight triggers may raise its own breakpoint request
// - time tag counts clock edges until an event, stored with it
// - input split 16/8/8/16; first three join a 16/24/32-bit counter
// - two probe clocks per board, selectable per segment and counter
// - per segment capture on rising or falling selected clock edge
// - time-tag part is only a 32-bit edge counter
// - expansion adds 48 bits of event memory plus 255 time tags
// - eight comparators of 48 bits, 96 bits with expansion fitted
// - probe bits stored raw; polarity affects interpretation only
// - 16-bit pass count per trigger delays its output to N matches
// - triggers on one level are ORed; first firing satisfies it
// - sequence-start mode stores the next 255 qualified events
//------------------------------------------------------------
`ifndef LSTC_DEFS_SVH
`define LSTC_DEFS_SVH
`define LSTC_NREG 88
`define LSTC_R_CTRL 7'h00
`define LSTC_R_PRE 7'h01
`define LSTC_R_BRD0 7'h02
`define LSTC_R_BRD1 7'h03
`define LSTC_R_QVAL 7'h04
`define LSTC_R_QMSK 7'h07
`define LSTC_R_SENSE 7'h0A
`define LSTC_R_STAT 7'h0D
`define LSTC_R_RDIDX 7'h0E
`define LSTC_R_RDDAT 7'h0F
`define LSTC_R_TRG 7'h18
`define LSTC_TRG_STRIDE 8
`define LSTC_T_MSK 3
`define LSTC_T_CTL 6
`define LSTC_CFG_RST 32'h0000_0000
`define LSTC_C_RUN 0
`define LSTC_C_MODE 1
`define LSTC_C_DEPTH 3
`define LSTC_C_TTSEL 6
`define LSTC_B_USE 0
`define LSTC_B_CSEL 4
`define LSTC_B_EDGE 12
`define LSTC_T_PASS 0
`define LSTC_T_LVL 16
`define LSTC_T_INV 19
`define LSTC_T_BRK 20
`define LSTC_S_STOP 0
`define LSTC_S_ARM 1
`define LSTC_S_DONE 2
`define LSTC_S_LVL 3
`define LSTC_S_WPTR 8
`define LSTC_S_CNT 16
`define LSTC_BUF_DEPTH 255
`define LSTC_MCLK_MHZ 40
`define LSTC_SYNC_NS 100
`define LSTC_SYNC_CYC ((`LSTC_SYNC_NS * `LSTC_MCLK_MHZ) / 1000)
`endif

// File: lstc_pkg.sv
// types shared by the trace capture block
`default_nettype none
package lstc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_POST, ST_STOP} lstc_state_t;
  typedef enum logic [1:0] {MODE_START, MODE_END, MODE_PRE} lstc_mode_t;
endpackage
`default_nettype wire

// File: lstc_board.sv
// one 48-bit input register/counter with per-segment clock and edge
`include "lstc_defs.svh"
`default_nettype none
module lstc_board (
  input wire logic mclk, // master clock
  input wire logic arst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic [1:0] rise, // probe clock rising edges
  input wire logic [1:0] fall, // probe clock falling edges
  input wire logic [47:0] din, // synchronised probe bits
  input wire logic [31:0] cfg, // segment configuration word
  output logic ev_o, // event strobe
  output logic [47:0] word_o // event word
);
  import lstc_pkg::*;
  logic [2:0] use_t;
  logic [4:0] csel, edg, hit;
  logic [47:0] seg_q, seg_d, word_d, w;
  logic [31:0] cnt_q, cnt_d, sh1, sh0;
  logic [4:0] off1, off0;
  logic ev_d;

  assign use_t = cfg[`LSTC_B_USE +: 3];
  assign csel = cfg[`LSTC_B_CSEL +: 5];
  assign edg = cfg[`LSTC_B_EDGE +: 5];

  // edge seen by each segment and by the counter
  genvar k;
  for (k = 0; k < 5; k++) begin : g_hit
    assign hit[k] = edg[k] ? fall[csel[k]] : rise[csel[k]];
  end

  // segment capture, counter and event word
  always_comb begin
    seg_d = seg_q;
    if (hit[0]) seg_d[47:32] = din[47:32];
    if (hit[1]) seg_d[31:24] = din[31:24];
    if (hit[2]) seg_d[23:16] = din[23:16];
    if (hit[3]) seg_d[15:0] = din[15:0];
    cnt_d = hit[4] ? cnt_q + 32'h1 : cnt_q;
    if (hit[3]) cnt_d = 32'h0;
    off1 = use_t[2] ? 5'h08 : 5'h00;
    off0 = off1 + (use_t[1] ? 5'h08 : 5'h00);
    sh1 = cnt_q >> off1;
    sh0 = cnt_q >> off0;
    w = seg_d;
    if (use_t[2]) w[23:16] = cnt_q[7:0];
    if (use_t[1]) w[31:24] = sh1[7:0];
    if (use_t[0]) w[47:32] = sh0[15:0];
    ev_d = hit[3];
    word_d = hit[3] ? w : word_o;
  end

  // register segment state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      seg_q <= 48'h0;
      cnt_q <= 32'h0;
      ev_o <= 1'b0;
      word_o <= 48'h0;
    end else if (ce) begin
      seg_q <= seg_d;
      cnt_q <= cnt_d;
      ev_o <= ev_d;
      word_o <= word_d;
    end
  end
endmodule
`default_nettype wire

// File: lstc_trigger.sv
// one comparator with pass counter
`include "lstc_defs.svh"
`default_nettype none
module lstc_trigger (
  input wire logic mclk, // master clock
  input wire logic arst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic clr, // restart pass counting
  input wire logic ev, // event strobe
  input wire logic [95:0] data, // interpreted event data
  input wire logic [95:0] val, // compare value
  input wire logic [95:0] mask, // care bits
  input wire logic [31:0] ctl, // pass count and invert
  output logic fire_o // trigger pulse
);
  import lstc_pkg::*;
  logic [15:0] cnt_q, cnt_d, pass;
  logic match, fire_d;

  assign pass = ctl[`LSTC_T_PASS +: 16];
  assign match = ((((data ^ val) & mask) == 96'h0)) ^ ctl[`LSTC_T_INV];

  // count matches until the pass count is reached
  always_comb begin
    cnt_d = cnt_q;
    fire_d = 1'b0;
    if (clr) begin
      cnt_d = 16'h0;
    end else if (ev && match) begin
      if ({1'b0, cnt_q} + 17'h1 >= {1'b0, pass}) begin
        fire_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h1;
      end
    end
  end

  // register the counter and pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0;
      fire_o <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      fire_o <= fire_d;
    end
  end
endmodule
`default_nettype wire

// File: lstc_top.sv
// trace capture: sampling, trigger sequence, event buffer, bus slave
`include "lstc_defs.svh"
`default_nettype none
module lstc_top #(
  parameter bit EXP = 1'b1, // expansion and time-tag fitted
  parameter int NTRIG = 8 // comparator count
) (
  input wire logic mclk, // master clock
  input wire logic arst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic [1:0] pclk_a, // standard board probe clocks
  input wire logic [1:0] pclk_b, // expansion board probe clocks
  input wire logic [47:0] probe_a, // standard board probe bits
  input wire logic [47:0] probe_b, // expansion board probe bits
  input wire logic [8:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output logic sync_pulse, // sequence complete pulse
  output logic [NTRIG-1:0] brk_req // breakpoint requests
);
  import lstc_pkg::*;

  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  logic [99:0] pin_w, s1_q, s2_q;
  logic [3:0] s3_q, rise, fall;
  logic [2:0] warm_q;

  assign pin_w = {pclk_b, pclk_a, probe_b, probe_a};

  // two stages on every pin, third stage on clocks for edges
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 100'h0;
      s2_q <= 100'h0;
      s3_q <= 4'h0;
      warm_q <= 3'h0;
    end else if (ce) begin
      s1_q <= pin_w;
      s2_q <= s1_q;
      s3_q <= s2_q[99:96];
      warm_q <= {warm_q[1:0], 1'b1};
    end
  end

  // no edges until the edge stage holds a real pin level after reset
  assign rise = warm_q[2] ? s2_q[99:96] & ~s3_q : 4'h0;
  assign fall = warm_q[2] ? ~s2_q[99:96] & s3_q : 4'h0;

  //------------------------------------------------------------
  // register file storage and bus handshake
  //------------------------------------------------------------
  logic [31:0] cfg_q [`LSTC_NREG];
  logic [31:0] cfg_d [`LSTC_NREG];
  logic [6:0] idx;
  logic wait_d, wr_go, start;
  logic [31:0] rdata_d, rd, bmask, status;
  logic [127:0] rd_word;
  logic [127:0] buf_q [`LSTC_BUF_DEPTH];
  logic [7:0] rdidx;

  assign idx = avs_address[8:2];
  assign wr_go = avs_write && !avs_waitrequest;
  assign start = wr_go && idx == `LSTC_R_CTRL && avs_byteenable[0];
  assign rdidx = cfg_q[`LSTC_R_RDIDX][7:0];

  // indexes that software may write and read back
  function automatic logic is_rw(input logic [6:0] i);
    is_rw = i < `LSTC_R_STAT || i == `LSTC_R_RDIDX ||
      (i >= `LSTC_R_TRG && i < 7'(`LSTC_NREG));
  endfunction

  // byte lane mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bmask[8*b +: 8] = avs_byteenable[b] ? 8'hFF : 8'h00;
    end
  end

  // read mux over configuration, status and buffer words
  always_comb begin
    rd_word = (rdidx < 8'(`LSTC_BUF_DEPTH)) ? buf_q[rdidx] : 128'h0;
    rd = 32'h0;
    if (is_rw(idx)) begin
      rd = cfg_q[idx];
    end else if (idx == `LSTC_R_STAT) begin
      rd = status;
    end else if (idx >= `LSTC_R_RDDAT && idx < `LSTC_R_RDDAT + 7'h04) begin
      rd = rd_word[32*(idx - `LSTC_R_RDDAT) +: 32];
    end
    wait_d = 1'b1;
    rdata_d = avs_readdata;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      wait_d = 1'b0;
      rdata_d = rd;
    end
  end

  // configuration writes, byte lanes honoured
  always_comb begin
    for (int i = 0; i < `LSTC_NREG; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (wr_go && is_rw(idx)) begin
      cfg_d[idx] = (cfg_q[idx] & ~bmask) | (avs_writedata & bmask);
    end
  end

  // register bus state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      for (int i = 0; i < `LSTC_NREG; i++) begin
        cfg_q[i] <= `LSTC_CFG_RST;
      end
    end else if (ce) begin
      avs_waitrequest <= wait_d;
      avs_readdata <= rdata_d;
      for (int i = 0; i < `LSTC_NREG; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  //------------------------------------------------------------
  // input boards
  //------------------------------------------------------------
  logic ev0, ev1;
  logic [47:0] w0, w1, w1_g;
  logic [95:0] ev_data, sense, interp;

  // standard board sets the event pace
  lstc_board u_brd0 (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .rise(rise[1:0]),
    .fall(fall[1:0]),
    .din(s2_q[47:0]),
    .cfg(cfg_q[`LSTC_R_BRD0]),
    .ev_o(ev0),
    .word_o(w0)
  );

  // expansion board contributes its latest word
  lstc_board u_brd1 (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .rise(rise[3:2]),
    .fall(fall[3:2]),
    .din(s2_q[95:48]),
    .cfg(cfg_q[`LSTC_R_BRD1]),
    .ev_o(ev1),
    .word_o(w1)
  );

  assign w1_g = (EXP && (ev1 || !ev1)) ? w1 : 48'h0;
  assign ev_data = {w1_g, w0};
  assign sense = {cfg_q[`LSTC_R_SENSE + 7'h02],
    cfg_q[`LSTC_R_SENSE + 7'h01], cfg_q[`LSTC_R_SENSE]};
  assign interp = ev_data ^ sense;

  //------------------------------------------------------------
  // comparators and sequence level decode
  //------------------------------------------------------------
  logic [NTRIG-1:0] fire, lvl_hit, brk_en;
  logic [2:0] level_q, level_d;
  logic seq_hit;

  genvar t;
  for (t = 0; t < NTRIG; t++) begin : g_trg
    localparam int B = `LSTC_R_TRG + t * `LSTC_TRG_STRIDE;
    localparam int M = B + `LSTC_T_MSK;
    localparam int C = B + `LSTC_T_CTL;
    lstc_trigger u_trg (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(start),
      .ev(ev0),
      .data(interp),
      .val({cfg_q[B+2], cfg_q[B+1], cfg_q[B]}),
      .mask({cfg_q[M+2], cfg_q[M+1], cfg_q[M]}),
      .ctl(cfg_q[C]),
      .fire_o(fire[t])
    );
    assign lvl_hit[t] = fire[t] &&
      cfg_q[C][`LSTC_T_LVL +: 3] == level_q;
    assign brk_en[t] = cfg_q[C][`LSTC_T_BRK];
  end

  assign seq_hit = |lvl_hit;

  //------------------------------------------------------------
  // capture control and event buffer
  //------------------------------------------------------------
  lstc_state_t state_q, state_d;
  lstc_mode_t mode;
  logic [7:0] wptr_q, wptr_d, count_q, count_d, remain_q, remain_d;
  logic [7:0] post_n, pre;
  logic [31:0] tt_q, tt_d;
  logic [3:0] sync_cnt_q, sync_cnt_d;
  logic done_q, done_d, qual, wr_en, tt_rise, sync_d;
  logic [2:0] depth;
  logic [95:0] qval, qmsk;
  logic [127:0] ev_word;
  logic [NTRIG-1:0] brk_d;

  assign mode = lstc_mode_t'(cfg_q[`LSTC_R_CTRL][`LSTC_C_MODE +: 2]);
  assign depth = cfg_q[`LSTC_R_CTRL][`LSTC_C_DEPTH +: 3];
  assign pre = cfg_q[`LSTC_R_PRE][7:0];
  assign tt_rise = rise[cfg_q[`LSTC_R_CTRL][`LSTC_C_TTSEL]];
  assign qval = {cfg_q[`LSTC_R_QVAL + 7'h02],
    cfg_q[`LSTC_R_QVAL + 7'h01], cfg_q[`LSTC_R_QVAL]};
  assign qmsk = {cfg_q[`LSTC_R_QMSK + 7'h02],
    cfg_q[`LSTC_R_QMSK + 7'h01], cfg_q[`LSTC_R_QMSK]};
  assign qual = ((interp ^ qval) & qmsk) == 96'h0;
  assign ev_word = {(EXP ? tt_q : 32'h0), ev_data};

  // events stored after completion, per mode
  always_comb begin
    case (mode)
      MODE_START: post_n = 8'(`LSTC_BUF_DEPTH);
      MODE_END: post_n = 8'h00;
      MODE_PRE: post_n = 8'(`LSTC_BUF_DEPTH) - pre;
      default: post_n = 8'(`LSTC_BUF_DEPTH);
    endcase
  end

  // sequence, pointers, time tag and sync stretch
  always_comb begin
    state_d = state_q;
    level_d = level_q;
    wptr_d = wptr_q;
    count_d = count_q;
    remain_d = remain_q;
    done_d = done_q;
    wr_en = 1'b0;
    sync_cnt_d = (sync_cnt_q != 4'h0) ? sync_cnt_q - 4'h1 : 4'h0;
    tt_d = tt_rise ? tt_q + 32'h1 : tt_q;
    if (ev0) tt_d = 32'h0;
    case (state_q)
      ST_IDLE: begin
        state_d = ST_IDLE;
      end
      ST_ARM: begin
        wr_en = ev0 && qual;
        if (seq_hit) begin
          if (level_q == depth) begin
            done_d = 1'b1;
            sync_cnt_d = 4'(`LSTC_SYNC_CYC);
            level_d = 3'h0;
            if (post_n == 8'h00) begin
              state_d = ST_STOP;
            end else begin
              state_d = ST_POST;
              remain_d = post_n;
            end
          end else begin
            level_d = level_q + 3'h1;
          end
        end
      end
      ST_POST: begin
        wr_en = ev0 && qual;
        if (wr_en) begin
          remain_d = remain_q - 8'h01;
          if (remain_q == 8'h01) state_d = ST_STOP;
        end
      end
      ST_STOP: begin
        state_d = ST_STOP;
      end
      default: state_d = ST_IDLE;
    endcase
    if (wr_en) begin
      wptr_d = (wptr_q == 8'(`LSTC_BUF_DEPTH - 1)) ? 8'h00
        : wptr_q + 8'h01;
      if (count_q != 8'(`LSTC_BUF_DEPTH)) count_d = count_q + 8'h01;
    end
    if (start) begin
      state_d = cfg_d[`LSTC_R_CTRL][`LSTC_C_RUN] ? ST_ARM : ST_IDLE;
      level_d = 3'h0;
      wptr_d = 8'h00;
      count_d = 8'h00;
      remain_d = 8'h00;
      done_d = 1'b0;
    end
    sync_d = sync_cnt_d != 4'h0;
    brk_d = fire & brk_en;
  end

  // register capture state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      level_q <= 3'h0;
      wptr_q <= 8'h00;
      count_q <= 8'h00;
      remain_q <= 8'h00;
      done_q <= 1'b0;
      tt_q <= 32'h0;
      sync_cnt_q <= 4'h0;
      sync_pulse <= 1'b0;
      brk_req <= '0;
    end else if (ce) begin
      state_q <= state_d;
      level_q <= level_d;
      wptr_q <= wptr_d;
      count_q <= count_d;
      remain_q <= remain_d;
      done_q <= done_d;
      tt_q <= tt_d;
      sync_cnt_q <= sync_cnt_d;
      sync_pulse <= sync_d;
      brk_req <= brk_d;
    end
  end

  // event memory, 255 words of flip-flops
  always_ff @(posedge mclk) begin
    if (ce && wr_en) begin
      buf_q[wptr_q] <= ev_word;
    end
  end

  // status word
  always_comb begin
    status = 32'h0;
    status[`LSTC_S_STOP] = state_q == ST_STOP;
    status[`LSTC_S_ARM] = state_q == ST_ARM || state_q == ST_POST;
    status[`LSTC_S_DONE] = done_q;
    status[`LSTC_S_LVL +: 3] = level_q;
    status[`LSTC_S_WPTR +: 8] = wptr_q;
    status[`LSTC_S_CNT +: 8] = count_q;
  end
endmodule
`default_nettype wire

// File: lstc_chk_assertions.sv
// concurrent checks on the trace capture top ports
`default_nettype none
module lstc_chk #(
  parameter int NTRIG = 8 // comparator count
) (
  input wire logic mclk, // master clock
  input wire logic arst_n, // async reset
  input wire logic [8:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic sync_pulse, // completion pulse
  input wire logic [NTRIG-1:0] brk_req // breakpoint requests
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic req;
  logic gap;
  // any bus request, and word indexes that hold no register
  assign req = avs_read || avs_write;
  assign gap = (avs_address[8:2] inside {[7'h13:7'h17]}) ||
    (avs_address[8:2] >= 7'h58);
  //----------------------------------------
  // register bus handshake
  //----------------------------------------
  req_answer_a: assert property (req && avs_waitrequest |->
    ##[1:2] !avs_waitrequest) else $error("bus request not answered");
  wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ready held over one cycle");
  wait_cause_a: assert property (!avs_waitrequest |-> req)
    else $error("ready without a request");
  idle_ready_a: assert property (!req |=> avs_waitrequest)
    else $error("ready without a wait cycle");
  rdata_hold_a: assert property (avs_waitrequest |->
    $stable(avs_readdata)) else $error("read data moved while idle");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && gap
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  //----------------------------------------
  // capture side outputs
  //----------------------------------------
  sync_len_a: assert property ($rose(sync_pulse) |->
    sync_pulse [*4] ##1 !sync_pulse) else $error("sync pulse length");
  brk_pulse_a: assert property (brk_req != '0 |=>
    brk_req == '0) else $error("breakpoint held too long");
endmodule
bind lstc_top lstc_chk #(.NTRIG(NTRIG)) u_lstc_chk (
  .mclk(mclk),
  .arst_n(arst_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .sync_pulse(sync_pulse),
  .brk_req(brk_req)
);
`default_nettype wire

// File: lstc_probe_model.sv
// behavioural target logic: probe clocks and numbered probe data
`default_nettype none
module lstc_probe_model (
  input wire logic en, // let the probe clocks run
  input wire logic clr, // restart event numbering
  input wire logic [47:0] base, // fixed upper probe bits
  output logic [1:0] pclk_a, // standard board clocks
  output logic [1:0] pclk_b, // expansion board clocks
  output logic [47:0] probe_a, // standard board bits
  output logic [47:0] probe_b // expansion board bits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph;
  logic [15:0] n;
  // 200 ns clock, still while disabled; data moves on the fall
  initial begin
    ph = 1'b0;
    n = 16'h0;
    #37;
    forever begin
      #100;
      if (clr) begin
        n = 16'h0;
      end else if (en) begin
        if (ph) n = n + 16'h1;
        ph = !ph;
      end
    end
  end
  // clock 2 runs inverted; event number sits in the data segment
  assign pclk_a = {!ph, ph};
  assign pclk_b = {!ph, ph};
  assign probe_a = {base[47:16], n};
  assign probe_b = ~probe_a;
endmodule
`default_nettype wire

// File: lstc_top_test.sv
// self-checking bench for the trace capture top
`include "lstc_defs.svh"
`default_nettype none
module lstc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, arst_n, ce, avs_read, avs_write, pen, pclr, sync_d;
  logic [1:0] pclk_a, pclk_b;
  logic [47:0] probe_a, probe_b, base;
  logic [8:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv, rv, st;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, sync_pulse;
  logic [7:0] brk_req;
  int mismatches, n_compared, n_sync;
  int n_brk [8];
  logic [6:0] ridx [8] = '{7'h00, 7'h01, 7'h02, 7'h07, 7'h0A, 7'h0D,
    7'h1E, 7'h13};
  lstc_top #(.EXP(1'b1), .NTRIG(8)) u_lstc_top (
    .mclk(mclk), .arst_n(arst_n), .ce(ce),
    .pclk_a(pclk_a), .pclk_b(pclk_b),
    .probe_a(probe_a), .probe_b(probe_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sync_pulse(sync_pulse),
    .brk_req(brk_req));
  lstc_probe_model u_lstc_probe_model (
    .en(pen), .clr(pclr), .base(base), .pclk_a(pclk_a),
    .pclk_b(pclk_b), .probe_a(probe_a), .probe_b(probe_b));
  // 40 MHz master clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // count completion pulses and breakpoint cycles
  always @(posedge mclk) begin
    sync_d <= sync_pulse;
    if (sync_pulse === 1'b1 && sync_d !== 1'b1) n_sync++;
    for (int i = 0; i < 8; i++) if (brk_req[i] === 1'b1) n_brk[i]++;
  end
  //----------------------------------------
  // bus access, compare and expectation helpers
  //----------------------------------------
  task automatic acc(input logic w, input logic [6:0] idx,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= wd;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [31:0] d);
    logic [31:0] x;
    acc(1'b1, idx, d, x);
  endtask
  task automatic rd(input logic [6:0] idx, output logic [31:0] d);
    acc(1'b0, idx, 32'h0, d);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] ev_lo(input logic [15:0] n);
    return {base[31:16], n};
  endfunction
  function automatic logic [31:0] ev_hi(input logic [15:0] n);
    return {~n, base[47:32]};
  endfunction
  // newest event in pre mode: completion at 21, then 255 minus pre more
  function automatic logic [15:0] last_ev(input logic [7:0] pre);
    return 16'd276 - {8'h0, pre};
  endfunction
  function automatic logic [7:0] prv(input logic [7:0] i);
    return (i == 8'h00) ? 8'hFE : i - 8'h01;
  endfunction
  // read one buffer word back: raw board 0 bits, board 1 low 16 bits
  task automatic buf_chk(input logic [7:0] i, input logic [15:0] n);
    wr(`LSTC_R_RDIDX, {24'h0, i});
    rd(`LSTC_R_RDDAT, rdv);
    chk(rdv, ev_lo(n));
    rd(`LSTC_R_RDDAT + 7'h01, rdv);
    chk(rdv, ev_hi(n));
  endtask
  task automatic trg(input int t, input logic [31:0] v,
      input logic [31:0] m, input logic [31:0] c);
    wr(7'(`LSTC_R_TRG + 8 * t), v);
    wr(7'(`LSTC_R_TRG + 8 * t + 3), m);
    wr(7'(`LSTC_R_TRG + 8 * t + 6), c);
  endtask
  // arm with two levels, run target events until capture stops
  task automatic run(input logic [1:0] mode, input logic [31:0] qm);
    int k;
    pen <= 1'b0;
    pclr <= 1'b1;
    wr(`LSTC_R_QMSK, qm);
    wr(`LSTC_R_CTRL, 32'h0);
    wr(`LSTC_R_CTRL, {26'h0, 3'h1, mode, 1'b1});
    rd(`LSTC_R_STAT, st);
    chk({31'h0, st[2]}, 32'h0);
    n_sync = 0;
    foreach (n_brk[i]) n_brk[i] = 0;
    pclr <= 1'b0;
    pen <= 1'b1;
    k = 0;
    do begin
      rd(`LSTC_R_STAT, st);
      k++;
    end while (st[0] !== 1'b1 && k < 2000);
    if (k >= 2000) mismatches++;
    repeat (200) @(posedge mclk);
    pen <= 1'b0;
    rd(`LSTC_R_STAT, st);
    chk({29'h0, st[2:0]}, 32'h5);
    chk(32'(n_sync), 32'h1);
    chk({31'h0, n_brk[1] > 0}, 32'h1);
    chk(32'(n_brk[0] + n_brk[2]), 32'h0);
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard, well beyond all three capture runs
  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    wrap_up();
  end
  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 9'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    pen = 1'b0;
    pclr = 1'b1;
    mismatches = 0;
    n_compared = 0;
    rv = $urandom(71330);
    base = {16'($urandom), 32'($urandom)};
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    // reset values, unmapped and read-only places
    foreach (ridx[i]) begin
      rd(ridx[i], rdv);
      chk(rdv, 32'h0);
    end
    wr(`LSTC_R_STAT, 32'hFFFF_FFFF);
    rd(`LSTC_R_STAT, rdv);
    chk(rdv, 32'h0);
    rv = $urandom;
    wr(7'h13, rv);
    rd(7'h13, rdv);
    chk(rdv, 32'h0);
    wr(`LSTC_R_QVAL, rv);
    rd(`LSTC_R_QVAL, rdv);
    chk(rdv, rv);
    wr(`LSTC_R_QVAL, 32'h0);
    wr(`LSTC_R_PRE, rv);
    rd(`LSTC_R_PRE, rdv);
    chk(rdv & 32'hFF, rv & 32'hFF);
    // low true data segment; trigger 2 satisfies level 0 at event 3
    wr(`LSTC_R_SENSE, 32'h0000_FFFF);
    trg(0, 32'h0000_FE0B, 32'h0000_FFFF, 32'h0010_0000);
    trg(1, 32'h0000_000A, 32'h0000_000F, 32'h0011_0002);
    trg(2, 32'h0000_FFFC, 32'h0000_FFFF, 32'h0);
    for (int t = 3; t < 8; t++) trg(t, 32'h0, 32'h0, 32'h000F_0000);
    // start mode: 255 events after completion at event 21
    run(2'd0, 32'h0);
    chk({24'h0, st[23:16]}, 32'hFF);
    buf_chk(st[15:8], 16'd22);
    buf_chk(prv(st[15:8]), 16'd276);
    // end mode, odd events only: newest is the completing one
    run(2'd1, 32'h1);
    buf_chk(prv(st[15:8]), 16'd21);
    buf_chk(prv(prv(st[15:8])), 16'd19);
    // pre mode with the random pre count written earlier
    run(2'd2, 32'h0);
    buf_chk(prv(st[15:8]), last_ev(rv[7:0]));
    wrap_up();
  end
endmodule
`default_nettype wire
